//--- design/disk_card_params.svh
`ifndef DISK_CARD_PARAMS_SVH
`define DISK_CARD_PARAMS_SVH
// card select window, decoded on the four top address lines
`define CARD_SEL_TOP       4'h8
`define BLK_STATUS         2'h0
`define BLK_DATA           2'h1
`define BLK_MOTOR          2'h2
`define BLK_DMA            2'h3
// printed block base addresses
`define STATUS_RESET_OFS   24'h800000
`define CMD_DATA_OFS       24'h840000
`define MOTOR_CTRL_OFS     24'h880000
`define DMA_ENGINE_OFS     24'h8C0000
// reset values of the card's own control bits
`define MOTOR_RST_VAL      1'b0
`define CTRL_RST_RST_VAL   1'b1
// time each disk-controller strobe is held, in ns, then in 4 ns cycles
`define STROBE_NS          8
`define STROBE_CYC         ((`STROBE_NS + 3) / 4)
// fifo geometry
`define FIFO_DEPTH         16
`define FIFO_AW            4
`endif

//--- design/disk_card_pkg.sv
package disk_card_pkg;
    // dma sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ   = 3'b001,
        ST_WAITB = 3'b010,
        ST_ADDR  = 3'b011,
        ST_SYNC  = 3'b100,
        ST_DATA  = 3'b101,
        ST_DONE  = 3'b110
    } dma_state_t;

    // host-bus strobe group, true = asserted
    typedef struct packed {
        logic as;
        logic uds;
        logic lds;
        logic rd;
    } strobes_t;
endpackage : disk_card_pkg

//--- design/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    // storage array
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      rp_reg;
    logic             push;
    logic             pop;
    // extra pointer bit tells full from empty
    assign in_ready  = (wp_reg - rp_reg) != DEPTH[AW:0];
    assign out_valid = wp_reg != rp_reg;
    assign out_data  = mem[rp_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop) rp_reg <= rp_reg + 1'b1;
        end
    end
    // data store, no reset needed
    always_ff @(posedge clk) begin
        if (push) mem[wp_reg[AW-1:0]] <= in_data;
    end
endmodule : byte_fifo

//--- design/disk_card_host_bus_interface.sv
// Operation
// R01: forward disk request as bus request
// R02: host grants only after its cycle
// R03: after grant wait bus idle, then acknowledge
// R04: drive dma address on muxed and upper
// R05: latch low address on engine ale
// R06: stretch dma cycle until memory sync low
// R07: strobes idle until memory sync low
// R08: host drives memory sync per cycle window
// R09: strobes only after address is out
// R10: card-read: data on lane, read strobe
// R11: card-write: lane transceiver, write strobe
// R12: decode one megabyte in four blocks
// R13: status read: main low, extra high
// R14: status write sets controller reset
// R15: data block reaches controller data register
// R16: motor write on, read clears both
// R17: interrupt passes only while motor on
// R18: fourth block selects dma engine
// R19: software uses byte moves, word status
// R20: chain table fetched by dma engine
// R21: one byte per disk request
// R22: decode from six top address lines
// R23: upper on high lane, lower low
// R24: active-low bus request for dma
// R25: release strobes, bus, request after cycle
`timescale 1ns/1ps
`include "disk_card_params.svh"
module disk_card_host_bus_interface
    import disk_card_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // host bus, programmed access side
    input  wire logic [23:0] host_addr,
    input  wire logic        host_as_n,
    input  wire logic        host_uds_n,
    input  wire logic        host_lds_n,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_data_in,
    output logic      [15:0] host_data_out,
    output logic      [15:0] host_data_oe,
    // arbitration and sync
    output logic             bus_request_out_n,
    input  wire logic        bus_grant_in_n,
    input  wire logic        memory_slot_sync_n,
    // strobes driven as master, with enable
    output logic             addr_valid_strobe_n,
    output logic             upper_lane_strobe_n,
    output logic             lower_lane_strobe_n,
    output logic             rw_out,
    output logic             strobe_oe,
    output logic      [7:0]  upper_addr_out,
    output logic             upper_addr_oe,
    output logic             addr_latch_n,
    // dma engine side
    input  wire logic        disk_xfer_request_n,
    input  wire logic        engine_breq,
    output logic             engine_back,
    input  wire logic        engine_ale,
    input  wire logic [15:0] muxed_lines_in,
    input  wire logic [7:0]  engine_upper_addr,
    input  wire logic        engine_to_mem,
    output logic             engine_wait,
    output logic             engine_sel_n,
    // disk controller side
    input  wire logic [7:0]  ctrl_status,
    input  wire logic [7:0]  extra_status,
    input  wire logic [7:0]  ctrl_data_in,
    output logic      [7:0]  ctrl_data_out,
    output logic             ctrl_rd_n,
    output logic             ctrl_wr_n,
    output logic             ctrl_reset,
    output logic             motor_on,
    input  wire logic        ctrl_irq,
    output logic             host_irq
);
    // card state apart from the byte fifo in one struct
    typedef struct packed {
        dma_state_t  st;
        strobes_t    stb;
        logic        br;
        logic        back;
        logic        uaoe;
        logic [7:0]  ua;
        logic        alat;
        logic        motor;
        logic        crst;
        logic        irq;
        logic        sel;
        logic        rdn;
        logic        wrn;
        logic        esel;
        logic        ewait;
        logic        rw;
        logic [1:0]  cnt;
        logic        lo;
        logic        prev_as;
        logic [15:0] dout;
        logic [15:0] doe;
        logic [7:0]  cdout;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // byte path through the fifo toward the controller
    logic [7:0] fifo_out;
    logic       fifo_ovalid;
    logic       fifo_iready;
    logic       fifo_pop;
    logic       pio_ack;

    // block decode used by every programmed host access
    function automatic logic [2:0] blk_decode(input logic [23:0] a);
        // R22 six top lines
        blk_decode = {a[23:20] == `CARD_SEL_TOP, a[19:18]};
    endfunction : blk_decode

    // lane enables from the host data strobes, shared by status and data
    function automatic logic [15:0] lane_mask(input logic u_n,
                                              input logic l_n);
        lane_mask = {{8{!u_n}}, {8{!l_n}}};
    endfunction : lane_mask

    logic [2:0] dec;
    logic       hit;
    logic [1:0] blk;
    logic       new_cyc;
    assign dec     = blk_decode(host_addr);
    // R12 four quarter blocks
    assign hit     = dec[2];
    assign blk     = dec[1:0];
    assign new_cyc = !host_as_n && !s_reg.prev_as && s_reg.st == ST_IDLE;
    // R15 writes to the data block queue in the fifo
    assign pio_ack = new_cyc && hit && blk == `BLK_DATA && !host_rd;
    assign fifo_pop = fifo_ovalid && s_reg.wrn && s_reg.cnt == 2'd0
                      && !s_reg.sel;

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) byte_fifo_inst (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (host_lds_n ? host_data_in[15:8] : host_data_in[7:0]),
        .in_valid  (pio_ack),
        .in_ready  (fifo_iready),
        .out_data  (fifo_out),
        .out_valid (fifo_ovalid),
        .out_ready (fifo_pop)
    );

    // next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.prev_as = !host_as_n;
        // R17 interrupt gated by motor
        s_next.irq = ctrl_irq && s_reg.motor;
        if (s_reg.cnt != 2'd0) s_next.cnt = s_reg.cnt - 2'd1;
        // strobes to the controller end with the count
        if (s_reg.cnt == 2'd1) begin
            // read data taken at strobe end, once the controller settled
            if (!s_reg.rdn) s_next.dout = {ctrl_data_in, ctrl_data_in};
            s_next.rdn = 1'b1;
            s_next.wrn = 1'b1;
            s_next.sel = 1'b0;
        end
        // host strobe ends programmed drive, not our own master cycle
        if (host_as_n && !s_reg.back) begin
            s_next.doe  = 16'h0000;
            s_next.esel = 1'b1;
        end
        // queued controller writes drain one per strobe
        if (fifo_pop) begin
            s_next.cdout = fifo_out;
            s_next.wrn   = 1'b0;
            s_next.cnt   = 2'(`STROBE_CYC);
        end
        // programmed access, only while the card does not own the bus
        if (new_cyc && hit) begin
            case (blk)
                `BLK_STATUS: begin
                    if (host_rd) begin
                        // R13 main low, extra high
                        s_next.dout = {extra_status, ctrl_status};
                        s_next.doe  = lane_mask(host_uds_n, host_lds_n);
                    end else begin
                        // R14 reset line set
                        s_next.crst = 1'b1;
                    end
                end
                `BLK_DATA: begin
                    if (host_rd) begin
                        // R15 data register read
                        s_next.dout = {ctrl_data_in, ctrl_data_in};
                        // R23 only the strobed lane
                        s_next.doe  = lane_mask(host_uds_n, host_lds_n);
                        s_next.rdn  = 1'b0;
                        s_next.sel  = 1'b1;
                        s_next.cnt  = 2'(`STROBE_CYC);
                    end
                end
                `BLK_MOTOR: begin
                    // R16 motor on or both off
                    if (host_rd) begin
                        s_next.motor = 1'b0;
                        s_next.crst  = 1'b0;
                    end else begin
                        s_next.motor = 1'b1;
                    end
                end
                `BLK_DMA: begin
                    // R18 R20 engine select, chain setup
                    s_next.esel = 1'b0;
                end
                default: ;
            endcase
        end
        case (s_reg.st)
            ST_IDLE: begin
                // R01 forward request
                if (engine_breq && !disk_xfer_request_n) begin
                    s_next.br = 1'b1;
                    s_next.st = ST_REQ;
                end
            end
            ST_REQ: begin
                // R03 grant then bus idle
                if (!bus_grant_in_n && host_as_n) begin
                    s_next.back = 1'b1;
                    s_next.ewait = 1'b1;
                    s_next.st   = ST_WAITB;
                end
            end
            ST_WAITB: begin
                // R05 latch on ale
                if (engine_ale) begin
                    s_next.alat = 1'b1;
                    // R04 upper lines out
                    s_next.ua   = engine_upper_addr;
                    s_next.uaoe = 1'b1;
                    s_next.rw   = !engine_to_mem;
                    // lane bit is only valid while the address is out
                    s_next.lo   = muxed_lines_in[0];
                    s_next.st   = ST_ADDR;
                end
            end
            ST_ADDR: begin
                s_next.alat = 1'b0;
                s_next.st   = ST_SYNC;
            end
            ST_SYNC: begin
                // R06 wait for sync low
                if (!memory_slot_sync_n) begin
                    // R07 R09 strobes after address
                    s_next.stb.as = 1'b1;
                    s_next.stb.uds = !s_reg.lo;
                    s_next.stb.lds = s_reg.lo;
                    s_next.stb.rd  = s_reg.rw;
                    s_next.ewait   = 1'b0;
                    s_next.cnt     = 2'(`STROBE_CYC);
                    s_next.sel     = 1'b1;
                    // R10 R11 controller strobe per direction
                    if (s_reg.rw) s_next.wrn = 1'b0;
                    else s_next.rdn = 1'b0;
                    if (!s_reg.rw) begin
                        // R23 byte lane by address bit
                        s_next.doe  = s_reg.lo ? 16'h00FF
                                                        : 16'hFF00;
                        s_next.dout = {ctrl_data_in, ctrl_data_in};
                    end else begin
                        s_next.cdout = s_reg.lo
                                       ? host_data_in[7:0]
                                       : host_data_in[15:8];
                    end
                    s_next.st = ST_DATA;
                end
            end
            ST_DATA: begin
                // R21 one byte per request
                if (s_reg.cnt == 2'd0) s_next.st = ST_DONE;
            end
            ST_DONE: begin
                // R25 release everything
                s_next.stb  = '0;
                s_next.uaoe = 1'b0;
                s_next.doe  = 16'h0000;
                s_next.br   = 1'b0;
                s_next.back = 1'b0;
                s_next.st   = ST_IDLE;
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg       <= '0;
            s_reg.st    <= ST_IDLE;
            s_reg.motor <= `MOTOR_RST_VAL;
            s_reg.crst  <= `CTRL_RST_RST_VAL;
            s_reg.rdn   <= 1'b1;
            s_reg.wrn   <= 1'b1;
            s_reg.esel  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state flops
    // R24 active-low request
    assign bus_request_out_n   = !s_reg.br;
    assign engine_back         = s_reg.back;
    assign addr_valid_strobe_n = !s_reg.stb.as;
    assign upper_lane_strobe_n = !s_reg.stb.uds;
    assign lower_lane_strobe_n = !s_reg.stb.lds;
    assign rw_out              = s_reg.stb.rd;
    assign strobe_oe           = s_reg.back;
    assign upper_addr_out      = s_reg.ua;
    assign upper_addr_oe       = s_reg.uaoe;
    assign addr_latch_n        = !s_reg.alat;
    assign engine_wait         = s_reg.ewait;
    assign engine_sel_n        = s_reg.esel;
    assign host_data_out       = s_reg.dout;
    assign host_data_oe        = s_reg.doe;
    assign ctrl_data_out       = s_reg.cdout;
    assign ctrl_rd_n           = s_reg.rdn;
    assign ctrl_wr_n           = s_reg.wrn;
    assign ctrl_reset          = s_reg.crst;
    assign motor_on            = s_reg.motor;
    assign host_irq            = s_reg.irq;

    // checks
    property p_irq_gate;
        @(posedge clk) disable iff (!rst_n)
        !s_reg.motor |=> !host_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) // R17
        else $error("irq passed with motor off");

    property p_sync_strobe;
        @(posedge clk) disable iff (!rst_n)
        $rose(s_reg.stb.as) |-> !$past(memory_slot_sync_n);
    endproperty
    a_sync_strobe: assert property (p_sync_strobe) // R07
        else $error("strobe without memory sync low");

    property p_addr_first;
        @(posedge clk) disable iff (!rst_n)
        s_reg.stb.as |-> s_reg.uaoe;
    endproperty
    a_addr_first: assert property (p_addr_first) // R09
        else $error("strobe before address");

    property p_grant_back;
        @(posedge clk) disable iff (!rst_n)
        s_reg.back |-> s_reg.br;
    endproperty
    a_grant_back: assert property (p_grant_back) // R03
        else $error("ack without request");

    property p_release;
        @(posedge clk) disable iff (!rst_n)
        s_reg.st == ST_DONE |=> !s_reg.br && !s_reg.stb.as && !s_reg.uaoe;
    endproperty
    a_release: assert property (p_release) // R25
        else $error("bus not released");

    property p_motor_read;
        @(posedge clk) disable iff (!rst_n)
        new_cyc && hit && blk == `BLK_MOTOR && host_rd
        |=> !motor_on && !ctrl_reset;
    endproperty
    a_motor_read: assert property (p_motor_read) // R16
        else $error("motor read did not clear");

    property p_status_wr;
        @(posedge clk) disable iff (!rst_n)
        new_cyc && hit && blk == `BLK_STATUS && !host_rd |=> ctrl_reset;
    endproperty
    a_status_wr: assert property (p_status_wr) // R14
        else $error("reset not set by status write");

    property p_req;
        @(posedge clk) disable iff (!rst_n)
        s_reg.st == ST_IDLE && engine_breq && !disk_xfer_request_n
        |=> !bus_request_out_n;
    endproperty
    a_req: assert property (p_req) // R01
        else $error("request not forwarded");

    c_dma: cover property (@(posedge clk) s_reg.st == ST_DONE);
    c_stat: cover property (@(posedge clk) new_cyc && hit && blk == 2'd0);
    c_fifo: cover property (@(posedge clk) !fifo_iready);
endmodule : disk_card_host_bus_interface

//--- verif/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bus_request_out_n,
    input  wire logic host_as_n,
    input  wire logic slow,
    output logic      bus_grant_in_n,
    output logic      memory_slot_sync_n
);
    logic [2:0] phase_reg;  // position inside the memory slot
    logic [3:0] wait_reg;   // cycles the request has waited

    // slot phase counter, free running like the host timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 3'h0;
        end else begin
            phase_reg <= phase_reg + 3'h1;
        end
    end

    // sync high, then window
    // high for the first cpu state slot, low while the window is open
    assign memory_slot_sync_n = (phase_reg < 3'h3);

    // grant after own cycle
    // slow mode stretches arbitration; grant never lands mid-cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg       <= 4'h0;
            bus_grant_in_n <= 1'b1;
        end else if (bus_request_out_n) begin
            wait_reg       <= 4'h0;
            bus_grant_in_n <= 1'b1;
        end else if (host_as_n && (wait_reg >= (slow ? 4'hC : 4'h1))) begin
            bus_grant_in_n <= 1'b0;
        end else if (wait_reg != 4'hF) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : host_bus_model

//--- verif/disk_card_host_bus_interface_tb.sv
`timescale 1ns/1ps
module disk_card_host_bus_interface_tb;
    import disk_card_pkg::*;
    logic        clk = 0, rst_n = 0, slow = 0;
    logic [23:0] host_addr = 24'h000000;
    logic        host_as_n = 1, host_uds_n = 1, host_lds_n = 1;
    logic        host_rd = 1;
    logic [15:0] host_data_in = 16'h0000, host_data_out, host_data_oe;
    logic        bus_request_out_n, bus_grant_in_n, memory_slot_sync_n;
    logic        addr_valid_strobe_n, upper_lane_strobe_n;
    logic        lower_lane_strobe_n, rw_out, strobe_oe;
    logic [7:0]  upper_addr_out;
    logic        upper_addr_oe, addr_latch_n;
    logic        disk_xfer_request_n = 1, engine_breq = 0, engine_back;
    logic        engine_ale = 0, engine_to_mem = 0, engine_wait;
    logic        engine_sel_n;
    logic [15:0] muxed_lines_in = 16'h0000;
    logic [7:0]  engine_upper_addr = 8'h00;
    logic [7:0]  ctrl_status = 8'hC3, extra_status = 8'h5E;
    logic [7:0]  ctrl_data_in = 8'h96, ctrl_data_out;
    logic        ctrl_rd_n, ctrl_wr_n, ctrl_reset, motor_on;
    logic        ctrl_irq = 0, host_irq;
    int          err_total = 0, compares = 0, cycles = 0;
    int          rd_cnt = 0, wr_cnt = 0;  // controller strobe pulses

    disk_card_host_bus_interface disk_card_host_bus_interface_inst (
        .clk, .rst_n, .host_addr, .host_as_n, .host_uds_n, .host_lds_n,
        .host_rd, .host_data_in, .host_data_out, .host_data_oe,
        .bus_request_out_n, .bus_grant_in_n, .memory_slot_sync_n,
        .addr_valid_strobe_n, .upper_lane_strobe_n, .lower_lane_strobe_n,
        .rw_out, .strobe_oe, .upper_addr_out, .upper_addr_oe,
        .addr_latch_n, .disk_xfer_request_n, .engine_breq, .engine_back,
        .engine_ale, .muxed_lines_in, .engine_upper_addr, .engine_to_mem,
        .engine_wait, .engine_sel_n, .ctrl_status, .extra_status,
        .ctrl_data_in, .ctrl_data_out, .ctrl_rd_n, .ctrl_wr_n,
        .ctrl_reset, .motor_on, .ctrl_irq, .host_irq);

    host_bus_model host_bus_model_inst (
        .clk, .rst_n, .bus_request_out_n, .host_as_n, .slow,
        .bus_grant_in_n, .memory_slot_sync_n);

    // 250 MHz clock
    always #2 clk = ~clk;

    // count strobe pulses toward the disk controller
    always @(negedge ctrl_rd_n) rd_cnt++;
    always @(negedge ctrl_wr_n) wr_cnt++;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // inputs always move 1 ns after the rising edge
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic check1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check1

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check16

    // one host cycle; lanes = {uds_n, lds_n}; samples while strobe held
    task automatic pio(input logic [23:0] a, input logic rd,
                       input logic [1:0] lanes, input logic [15:0] wd,
                       output logic [15:0] q, output logic [15:0] oe,
                       output logic sel_n);
        step();
        host_addr = a;
        host_rd = rd;
        {host_uds_n, host_lds_n} = lanes;
        host_data_in = wd;
        host_as_n = 1'b0;
        repeat (3) step();
        q = host_data_out;
        oe = host_data_oe;
        sel_n = engine_sel_n;
        host_as_n = 1'b1;
        {host_uds_n, host_lds_n} = 2'b11;
        repeat (4) step();
    endtask : pio

    task automatic test_decode();
        logic [15:0] q, oe;
        logic        s;
        int          r0;
        r0 = rd_cnt;
        pio(24'h83FFFE, 1'b1, 2'b00, 16'h0000, q, oe, s);
        check16(q, {extra_status, ctrl_status});
        check16(oe, 16'hFFFF);
        pio(24'h840001, 1'b1, 2'b10, 16'h0000, q, oe, s);
        check16({8'h00, q[7:0]}, {8'h00, ctrl_data_in});
        check16(oe, 16'h00FF);
        pio(24'h840000, 1'b1, 2'b01, 16'h0000, q, oe, s);
        check16({8'h00, q[15:8]}, {8'h00, ctrl_data_in});
        check16(oe, 16'hFF00);
        check16(16'(rd_cnt - r0), 16'h0002);
        pio(24'h8C0000, 1'b1, 2'b10, 16'h0000, q, oe, s);
        check1(s, 1'b0);
        pio(24'h8FFFFF, 1'b0, 2'b10, 16'h0001, q, oe, s);
        check1(s, 1'b0);
        pio(24'h900000, 1'b1, 2'b00, 16'h0000, q, oe, s);
        check16(oe, 16'h0000);
        check1(s, 1'b1);
        pio(24'h7FFFFE, 1'b1, 2'b00, 16'h0000, q, oe, s);
        check16(oe, 16'h0000);
        $display("test decode done");
    endtask : test_decode

    task automatic test_motor_reset();
        logic [15:0] q, oe;
        logic        s;
        ctrl_irq = 1'b1;
        step();
        check1(ctrl_reset, 1'b1);
        check1(host_irq, 1'b0);
        pio(24'h880000, 1'b1, 2'b10, 16'h0000, q, oe, s);
        check1(ctrl_reset, 1'b0);
        pio(24'h820010, 1'b0, 2'b10, 16'h0000, q, oe, s);
        check1(ctrl_reset, 1'b1);
        pio(24'h8BFFFF, 1'b0, 2'b10, 16'h0000, q, oe, s);
        check1(motor_on, 1'b1);
        check1(ctrl_reset, 1'b1);
        check1(host_irq, 1'b1);
        pio(24'h880002, 1'b1, 2'b10, 16'h0000, q, oe, s);
        check1(motor_on, 1'b0);
        check1(ctrl_reset, 1'b0);
        check1(host_irq, 1'b0);
        ctrl_irq = 1'b0;
        $display("test motor_reset done");
    endtask : test_motor_reset

    task automatic test_data_write();
        logic [15:0] q, oe;
        logic        s;
        int          w0;
        w0 = wr_cnt;
        pio(24'h840001, 1'b0, 2'b10, 16'h005A, q, oe, s);
        pio(24'h840001, 1'b0, 2'b10, 16'h00A5, q, oe, s);
        pio(24'h840000, 1'b0, 2'b01, 16'h3C00, q, oe, s);
        repeat (30) step();
        check16(16'(wr_cnt - w0), 16'h0003);
        check16({8'h00, ctrl_data_out}, 16'h003C);
        $display("test data_write done");
    endtask : test_data_write

    // one dma byte; slow_g also holds a foreign host cycle open
    task automatic dma_cycle(input logic to_mem, input logic slow_g);
        int   n, r0, w0;
        logic s;
        r0 = rd_cnt;
        w0 = wr_cnt;
        step();
        slow = slow_g;
        engine_to_mem = to_mem;
        host_addr = 24'h400000;
        host_as_n = ~slow_g;
        disk_xfer_request_n = 1'b0;
        engine_breq = 1'b1;
        for (n = 0; n < 20 && bus_request_out_n !== 1'b0; n++) step();
        check1(bus_request_out_n, 1'b0);
        repeat (10) step();
        check1(engine_back, ~slow_g);
        host_as_n = 1'b1;
        for (n = 0; n < 40 && engine_back !== 1'b1; n++) step();
        check1(bus_grant_in_n, 1'b0);
        check1(engine_wait, 1'b1);
        check1(addr_valid_strobe_n, 1'b1);
        engine_upper_addr = to_mem ? 8'h12 : 8'hED;
        muxed_lines_in = {15'h1A20, to_mem};
        host_data_in = 16'h7E00;
        engine_ale = 1'b1;
        step();
        engine_ale = 1'b0;
        for (n = 0; n < 5 && addr_latch_n !== 1'b0; n++) step();
        check1(addr_latch_n, 1'b0);
        step();
        check16({8'h00, upper_addr_out}, {8'h00, engine_upper_addr});
        check1(upper_addr_oe, 1'b1);
        s = memory_slot_sync_n;
        for (n = 0; n < 40 && addr_valid_strobe_n !== 1'b0; n++) begin
            s = memory_slot_sync_n;
            step();
        end
        check1(s, 1'b0);
        check1(upper_addr_oe, 1'b1);
        check1(lower_lane_strobe_n, ~to_mem);
        check1(upper_lane_strobe_n, to_mem);
        check1(rw_out, ~to_mem);
        check1(engine_wait, 1'b0);
        check1(strobe_oe, 1'b1);
        check16(host_data_oe, {8'h00, {8{to_mem}}});
        if (!to_mem) check16({8'h00, ctrl_data_out}, 16'h007E);
        disk_xfer_request_n = 1'b1;
        engine_breq = 1'b0;
        for (n = 0; n < 40 && bus_request_out_n !== 1'b1; n++) step();
        check1(bus_request_out_n, 1'b1);
        check1(strobe_oe, 1'b0);
        check1(upper_addr_oe, 1'b0);
        check1(addr_valid_strobe_n, 1'b1);
        check16(16'(rd_cnt - r0), {15'h0000, to_mem});
        check16(16'(wr_cnt - w0), {15'h0000, ~to_mem});
        $display("test dma to_mem=%0d slow=%0d done", to_mem, slow_g);
    endtask : dma_cycle

    // main sequence
    initial begin
        repeat (10) step();
        rst_n = 1'b1;
        test_motor_reset();
        test_decode();
        test_data_write();
        dma_cycle(1'b1, 1'b0);
        dma_cycle(1'b0, 1'b1);
        dma_cycle(1'b1, 1'b1);
        complete_run();
    end
endmodule : disk_card_host_bus_interface_tb
